// file: rtl/qspi_prog_host.sv
// Quad flash program/erase host: AXI4-Lite registers in, flash pins out
`timescale 1ns/10ps
module qspi_prog_host
  import qspi_host_pkg::*;
#(
  parameter logic [7:0] SCLK_HALF = 8'(qspi_host_pkg::SCLK_HALF_CYC),
  parameter logic [7:0] CS_GAP    = 8'(qspi_host_pkg::CS_GAP_CYC)
) (
  // Clock, reset, enable
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        ce,
  // AXI4-Lite write
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Flash pins
  output logic             flashCsN,
  output logic             flashSclk,
  input  wire logic [3:0]  ioIn,
  output logic [3:0]       ioOut,
  output logic [3:0]       ioOe
);
  import qspi_host_pkg::*;

  typedef struct packed {
    state_t      state;
    kind_t       kind;
    logic        addr4;
    logic        ded4;
    logic [31:0] addr;
    logic [7:0]  lenM1;
    logic        busy;
    logic        done;
    logic        welErr;
    logic        notExec;
    logic [7:0]  lastSr;
    logic        welCheck;
    logic [31:0] sh;
    logic [5:0]  bitsLeft;
    logic        quad;
    logic [7:0]  cnt;
    logic [7:0]  dataIdx;
    logic [3:0]  syncA;
    logic [3:0]  syncB;
    logic        csN;
    logic        sclk;
    logic [3:0]  ioOut;
    logic [3:0]  ioOe;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        bufWe;
    logic [7:0]  bufWAddr;
    logic [7:0]  bufWData;
  } st_t;

  st_t        st_q;
  st_t        st_d;
  logic [7:0] rdByte;
  logic       shifting;
  logic       last;
  logic [5:0] step;

  function automatic logic [7:0] opcodeFor(kind_t k, logic ded4);
    logic [7:0] op;
    op = OP_QPP;
    unique case (k)
      KIND_QPP:  op = ded4 ? OP_QPP_4B : OP_QPP;
      KIND_EQPP: op = ded4 ? OP_EQPP_4B : OP_EQPP;
      KIND_SE:   op = ded4 ? OP_SE_4B : OP_SE;
      KIND_ERASE_32K_CMD: op = ded4 ? OP_ERASE_32K_CMD_4B : OP_ERASE_32K_CMD;
      KIND_ERASE_64K_CMD: op = ded4 ? OP_ERASE_64K_CMD_4B : OP_ERASE_64K_CMD;
      default:   op = OP_QPP;
    endcase
    return op;
  endfunction

  function automatic logic kindValid(logic [2:0] k);
    return k <= KIND_ERASE_64K_CMD;
  endfunction

  function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] nw, logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Select low and shift out one opcode byte on the single lane
  function automatic st_t beginOp(st_t s, logic [7:0] op, state_t nxt);
    st_t r;
    r = s;
    r.state    = nxt;
    r.csN      = 1'b0;
    r.sclk     = 1'b0;
    r.sh       = {op, 24'h000000};
    r.bitsLeft = BITS_BYTE;
    r.quad     = 1'b0;
    r.cnt      = 8'h00;
    return r;
  endfunction

  // Deselect only after the last full byte, never mid-byte
  function automatic st_t enterGap(st_t s, state_t nxt);
    st_t r;
    r = s;
    r.state = nxt;
    r.csN   = 1'b1;
    r.sclk  = 1'b0;
    r.cnt   = 8'h00;
    r.ioOe  = 4'h0;
    return r;
  endfunction

  function automatic st_t finish(st_t s);
    st_t r;
    r = s;
    r.state = S_IDLE;
    r.busy  = 1'b0;
    r.done  = 1'b1;
    return r;
  endfunction

  page_buffer #(
    .DW(8),
    .AW(8)
  ) u_buf (
    .clk  (clk),
    .ce   (ce),
    .we   (st_q.bufWe),
    .wAddr(st_q.bufWAddr),
    .wData(st_q.bufWData),
    .rAddr(st_q.dataIdx),
    .rData(rdByte)
  );

  assign shifting = st_q.state inside {S_WRITE_ENABLE_CMD_OP, S_CMD_OP, S_CMD_ADDR, S_DATA,
                                       S_POLL_OP, S_POLL_RD};
  assign step     = st_q.quad ? STEP_QUAD : STEP_SINGLE;

  always_comb begin
    st_d       = st_q;
    last       = 1'b0;
    // Pin samples: first stage feeds only the second
    st_d.syncA = ioIn;
    st_d.syncB = st_q.syncA;
    st_d.bufWe = 1'b0;

    // AXI handshakes
    if (st_q.awready) begin
      st_d.awready = 1'b0;
      st_d.wready  = 1'b0;
    end
    if (st_q.bvalid && bready) begin
      st_d.bvalid = 1'b0;
    end
    if (st_q.arready) begin
      st_d.arready = 1'b0;
    end
    if (st_q.rvalid && rready) begin
      st_d.rvalid = 1'b0;
    end

    if (awvalid && wvalid && !st_q.bvalid && !st_q.awready) begin
      st_d.awready = 1'b1;
      st_d.wready  = 1'b1;
      st_d.bvalid  = 1'b1;
      st_d.bresp   = RESP_OKAY;
      case (awaddr)
        REG_CTRL: begin
          // Start ignored while busy or with an unknown kind
          if (wstrb[0] && wdata[CTRL_START] && !st_q.busy &&
              kindValid(wdata[CTRL_KIND_LSB +: 3])) begin
            st_d         = beginOp(st_d, OP_WRITE_ENABLE_CMD, S_WRITE_ENABLE_CMD_OP);
            st_d.kind    = kind_t'(wdata[CTRL_KIND_LSB +: 3]);
            st_d.addr4   = wdata[CTRL_ADDR4];
            st_d.ded4    = wdata[CTRL_DED4];
            st_d.busy    = 1'b1;
            st_d.done    = 1'b0;
            st_d.welErr  = 1'b0;
            st_d.notExec = 1'b0;
            st_d.dataIdx = 8'h00;
          end
        end
        REG_ADDR: begin
          if (!st_q.busy) begin
            st_d.addr = merge(st_q.addr, wdata, wstrb);
          end
        end
        REG_LEN: begin
          // Count minus one, so a frame never exceeds one page
          if (!st_q.busy && wstrb[0]) begin
            st_d.lenM1 = wdata[7:0];
          end
        end
        REG_BUF: begin
          if (!st_q.busy && wstrb[0] && wstrb[1]) begin
            st_d.bufWe    = 1'b1;
            st_d.bufWAddr = wdata[BUF_IDX_LSB +: 8];
            st_d.bufWData = wdata[7:0];
          end
        end
        REG_STATUS: begin
        end
        default: st_d.bresp = RESP_SLVERR;
      endcase
    end

    if (arvalid && !st_q.rvalid && !st_q.arready) begin
      st_d.arready = 1'b1;
      st_d.rvalid  = 1'b1;
      st_d.rresp   = RESP_OKAY;
      case (araddr)
        REG_CTRL:   st_d.rdata = {26'h0000000, st_q.ded4, st_q.addr4, st_q.kind, 1'b0};
        REG_ADDR:   st_d.rdata = st_q.addr;
        REG_LEN:    st_d.rdata = {24'h000000, st_q.lenM1};
        REG_STATUS: st_d.rdata = {16'h0000, st_q.lastSr, 4'h0, st_q.notExec,
                                  st_q.welErr, st_q.done, st_q.busy};
        REG_BUF:    st_d.rdata = 32'h00000000;
        default: begin
          st_d.rdata = 32'h00000000;
          st_d.rresp = RESP_SLVERR;
        end
      endcase
    end

    // Bit engine: drive on falling edge, device latches on rising, sample late
    if (shifting) begin
      if (st_q.cnt == 8'h00) begin
        st_d.sclk = 1'b0;
        if (st_q.quad) begin
          st_d.ioOut = st_q.sh[31:28];
          st_d.ioOe  = OE_QUAD;
        end else begin
          st_d.ioOut = {IO_HOLD_HI, 1'b0, st_q.sh[31]};
          st_d.ioOe  = OE_SINGLE;
        end
      end
      if (st_q.cnt == SCLK_HALF) begin
        st_d.sclk = 1'b1;
      end
      if (st_q.cnt == 8'(2 * SCLK_HALF - 8'h01)) begin
        st_d.cnt      = 8'h00;
        st_d.sh       = st_q.quad ? {st_q.sh[27:0], st_q.syncB} : {st_q.sh[30:0], st_q.syncB[1]};
        st_d.bitsLeft = st_q.bitsLeft - step;
        last          = (st_q.bitsLeft == step);
      end else begin
        st_d.cnt = st_q.cnt + 8'h01;
      end
    end

    unique case (st_q.state)
      S_IDLE: begin
      end
      S_WRITE_ENABLE_CMD_OP: begin
        if (last) begin
          st_d          = enterGap(st_d, S_WRITE_ENABLE_CMD_GAP);
          st_d.welCheck = 1'b1;
        end
      end
      S_WRITE_ENABLE_CMD_GAP, S_CMD_GAP, S_POLL_GAP: begin
        st_d.ioOe = 4'h0;
        if (st_q.cnt == CS_GAP - 8'h01) begin
          if (st_q.state == S_WRITE_ENABLE_CMD_GAP) begin
            st_d = beginOp(st_d, OP_RDSR, S_POLL_OP);
          end else if (st_q.state == S_CMD_GAP) begin
            st_d          = beginOp(st_d, OP_RDSR, S_POLL_OP);
            st_d.welCheck = 1'b0;
          end else if (st_q.welCheck) begin
            // Skip the command if the latch did not set
            if (!st_q.lastSr[SR_WEL]) begin
              st_d        = finish(st_d);
              st_d.welErr = 1'b1;
            end else begin
              st_d = beginOp(st_d, opcodeFor(st_q.kind, st_q.ded4), S_CMD_OP);
            end
          end else if (st_q.lastSr[SR_WIP]) begin
            st_d = beginOp(st_d, OP_RDSR, S_POLL_OP);
          end else begin
            // Latch still set after the cycle means the device refused it
            st_d         = finish(st_d);
            st_d.notExec = st_q.lastSr[SR_WEL];
          end
        end else begin
          st_d.cnt = st_q.cnt + 8'h01;
        end
      end
      S_POLL_OP: begin
        if (last) begin
          st_d.state    = S_POLL_RD;
          st_d.bitsLeft = BITS_BYTE;
          st_d.quad     = 1'b0;
        end
      end
      S_POLL_RD: begin
        if (last) begin
          st_d        = enterGap(st_d, S_POLL_GAP);
          st_d.lastSr = st_d.sh[7:0];
        end
      end
      S_CMD_OP: begin
        // Address goes out unmasked, all 32 bits in four-byte mode or with a dedicated opcode, else the low 24; the device picks sector or block from it
        if (last) begin
          st_d.state    = S_CMD_ADDR;
          st_d.sh       = (st_q.addr4 || st_q.ded4) ? st_q.addr
                                                    : {st_q.addr[23:0], 8'h00};
          st_d.bitsLeft = (st_q.addr4 || st_q.ded4) ? BITS_ADDR32 : BITS_ADDR24;
          st_d.quad     = (st_q.kind == KIND_EQPP);
        end
      end
      S_CMD_ADDR: begin
        if (last) begin
          if (st_q.kind == KIND_QPP || st_q.kind == KIND_EQPP) begin
            st_d.state = S_DNEXT;
          end else begin
            st_d = enterGap(st_d, S_CMD_GAP);
          end
        end
      end
      S_DNEXT: begin
        // One cycle for the buffer's registered read
        st_d.state = S_DLOAD;
        // Clock falls only here, so the last bit keeps a full high phase
        st_d.sclk  = 1'b0;
      end
      S_DLOAD: begin
        st_d.state    = S_DATA;
        st_d.sh       = {rdByte, 24'h000000};
        st_d.bitsLeft = BITS_BYTE;
        st_d.quad     = 1'b1;
        st_d.cnt      = 8'h00;
      end
      S_DATA: begin
        if (last) begin
          if (st_q.dataIdx == st_q.lenM1) begin
            st_d = enterGap(st_d, S_CMD_GAP);
          end else begin
            st_d.dataIdx = st_q.dataIdx + 8'h01;
            st_d.state   = S_DNEXT;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_q     <= '0;
      st_q.csN <= 1'b1;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign awready   = st_q.awready;
  assign wready    = st_q.wready;
  assign bvalid    = st_q.bvalid;
  assign bresp     = st_q.bresp;
  assign arready   = st_q.arready;
  assign rvalid    = st_q.rvalid;
  assign rdata     = st_q.rdata;
  assign rresp     = st_q.rresp;
  assign flashCsN  = st_q.csN;
  assign flashSclk = st_q.sclk;
  assign ioOut     = st_q.ioOut;
  assign ioOe      = st_q.ioOe;

endmodule

// file: rtl/qspi_host_pkg.sv
// Constants, encodings and register map of the quad flash program/erase host
package qspi_host_pkg;

  // Timing, in ns, and derived clock counts (least times round up)
  localparam int CLK_NS        = 50;
  localparam int SCLK_HALF_NS  = 200;
  localparam int CS_GAP_NS     = 200;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int CS_GAP_CYC    = (CS_GAP_NS + CLK_NS - 1) / CLK_NS;

  // Flash opcodes: first of each pair follows the address mode, second is 4-byte
  localparam logic [7:0] OP_WRITE_ENABLE_CMD      = 8'h06;
  localparam logic [7:0] OP_RDSR      = 8'h05;
  localparam logic [7:0] OP_QPP       = 8'h32;
  localparam logic [7:0] OP_QPP_4B    = 8'h34;
  localparam logic [7:0] OP_EQPP      = 8'hc2;
  localparam logic [7:0] OP_EQPP_4B   = 8'h3e;
  localparam logic [7:0] OP_SE        = 8'h20;
  localparam logic [7:0] OP_SE_4B     = 8'h21;
  localparam logic [7:0] OP_ERASE_32K_CMD      = 8'h52;
  localparam logic [7:0] OP_ERASE_32K_CMD_4B   = 8'h5c;
  localparam logic [7:0] OP_ERASE_64K_CMD      = 8'hd8;
  localparam logic [7:0] OP_ERASE_64K_CMD_4B   = 8'hdc;

  // Flash status bits
  localparam int SR_WIP = 0;
  localparam int SR_WEL = 1;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_LEN    = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_BUF    = 8'h10;

  // Field positions
  localparam int CTRL_START    = 0;
  localparam int CTRL_KIND_LSB = 1;
  localparam int CTRL_ADDR4    = 4;
  localparam int CTRL_DED4     = 5;
  localparam int BUF_IDX_LSB   = 8;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Pin drive patterns: IO2/IO3 held high as protect/hold in single-lane phases
  localparam logic [3:0] OE_SINGLE  = 4'hd;
  localparam logic [3:0] OE_QUAD    = 4'hf;
  localparam logic [1:0] IO_HOLD_HI = 2'h3;

  localparam logic [5:0] BITS_BYTE   = 6'h08;
  localparam logic [5:0] BITS_ADDR24 = 6'h18;
  localparam logic [5:0] BITS_ADDR32 = 6'h20;
  localparam logic [5:0] STEP_SINGLE = 6'h01;
  localparam logic [5:0] STEP_QUAD   = 6'h04;

  typedef enum logic [2:0] {
    KIND_QPP  = 3'b000,
    KIND_EQPP = 3'b001,
    KIND_SE   = 3'b010,
    KIND_ERASE_32K_CMD = 3'b011,
    KIND_ERASE_64K_CMD = 3'b100
  } kind_t;

  typedef enum logic [3:0] {
    S_IDLE     = 4'b0000,
    S_WRITE_ENABLE_CMD_OP  = 4'b0001,
    S_WRITE_ENABLE_CMD_GAP = 4'b0010,
    S_POLL_OP  = 4'b0011,
    S_POLL_RD  = 4'b0100,
    S_POLL_GAP = 4'b0101,
    S_CMD_OP   = 4'b0110,
    S_CMD_ADDR = 4'b0111,
    S_DNEXT    = 4'b1000,
    S_DLOAD    = 4'b1001,
    S_DATA     = 4'b1010,
    S_CMD_GAP  = 4'b1011
  } state_t;

endpackage

// file: rtl/page_buffer.sv
// Page data buffer with registered read port
`timescale 1ns/10ps
module page_buffer #(
  parameter int DW = 8,
  parameter int AW = 8
) (
  // Clocking
  input  wire logic          clk,
  input  wire logic          ce,
  // Write port
  input  wire logic          we,
  input  wire logic [AW-1:0] wAddr,
  input  wire logic [DW-1:0] wData,
  // Read port
  input  wire logic [AW-1:0] rAddr,
  output logic      [DW-1:0] rData
);

  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge clk) begin
    if (ce) begin
      if (we) begin
        mem[wAddr] <= wData;
      end
      rData <= mem[rAddr];
    end
  end

endmodule

// file: dv/qspi_prog_host_asserts.sv
// Port-level assertions for the quad flash program/erase host
`timescale 1ns/10ps
module qspi_prog_host_asserts #(
  parameter logic [7:0] SCLK_HALF = 8'h04,
  parameter logic [7:0] CS_GAP    = 8'h04
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // AXI4-Lite
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic [7:0]  araddr,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  // Flash pins
  input wire logic        flashCsN,
  input wire logic        flashSclk,
  input wire logic [3:0]  ioOut,
  input wire logic [3:0]  ioOe
);
  import qspi_host_pkg::*;
  logic [7:0]  hiCnt;
  logic [7:0]  csHi;
  logic [11:0] bitCnt;
  logic        sclkPrev;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Saturate so a long idle never wraps below the gap
  always_ff @(posedge clk) begin
    if (reset) begin
      hiCnt <= 8'h00;
      csHi <= 8'h00;
      bitCnt <= 12'h000;
      sclkPrev <= 1'b0;
    end else begin
      hiCnt <= flashSclk ? hiCnt + 8'h01 : 8'h00;
      csHi <= !flashCsN ? 8'h00 : (csHi == 8'hff ? csHi : csHi + 8'h01);
      sclkPrev <= flashSclk;
      if (flashCsN) bitCnt <= 12'h000;
      else if (flashSclk && !sclkPrev) bitCnt <= bitCnt + (ioOe == OE_QUAD ? 12'h004 : 12'h001);
    end
  end
  idle_after_reset_a: assert property ($fell(reset) |-> flashCsN && !flashSclk && ioOe == 4'h0)
    else $error("flash pins not idle after reset");
  sclk_in_frame_a: assert property (flashSclk |-> !flashCsN)
    else $error("serial clock high outside a frame");
  // A frame's last bit is cut one cycle short by the deselect
  sclk_high_len_a: assert property ($fell(flashSclk) |->
      hiCnt == (flashCsN ? SCLK_HALF - 8'h01 : SCLK_HALF))
    else $error("serial clock high phase wrong length");
  data_steady_a: assert property (
      flashSclk |=> !flashSclk || $stable(ioOut) && $stable(ioOe))
    else $error("data lines moved while clock high");
  byte_boundary_a: assert property (
      $rose(flashCsN) |-> bitCnt[2:0] == 3'h0 && bitCnt >= 12'h008)
    else $error("chip select rose off a byte boundary");
  cs_gap_a: assert property ($fell(flashCsN) |-> csHi >= CS_GAP)
    else $error("chip select gap too short");
  lane_drive_a: assert property (
      flashSclk |-> ioOe == OE_QUAD || ioOe == OE_SINGLE && ioOut[3:2] == IO_HOLD_HI)
    else $error("bad lane drive pattern");
  wr_answer_a: assert property (awvalid && wvalid && !bvalid && !awready |=> awready && wready && bvalid)
    else $error("write not answered next cycle");
  rd_answer_a: assert property (arvalid && !rvalid && !arready |=> arready && rvalid)
    else $error("read not answered next cycle");
  unmapped_rd_a: assert property (arvalid && !rvalid && !arready && araddr > 8'h13 |=> rresp == RESP_SLVERR && rdata == 32'h0)
    else $error("unmapped read not refused");
endmodule
bind qspi_prog_host qspi_prog_host_asserts #(.SCLK_HALF(SCLK_HALF), .CS_GAP(CS_GAP)) chk (
  .clk, .reset, .awvalid, .awready, .wvalid, .wready, .bvalid, .araddr, .arvalid,
  .arready, .rdata, .rresp, .rvalid, .flashCsN, .flashSclk, .ioOut, .ioOe);

// file: dv/flash_model.sv
// Behavioural quad flash device answering the program/erase host
`timescale 1ns/10ps
module flash_model #(
  parameter int BUSY_NS = 20000
) (
  // Host pins
  input  wire logic       flashCsN,
  input  wire logic       flashSclk,
  input  wire logic [3:0] ioOut,
  input  wire logic [3:0] ioOe,
  output logic      [3:0] ioIn,
  // Bench controls
  input  wire logic       fourByte,
  input  wire logic       protect,
  input  wire logic       wrenDead
);
  logic [7:0]   page [256];
  logic [7:0]   lat [256];
  logic [255:0] hit;
  logic [7:0]   sh, op, lastOp, outSh;
  logic [31:0]  addr, lastAddr;
  logic [3:0]   bc;
  logic         write_enable_latch, d1, drv, quad, prog, erase;
  int           byn, nDat, alen, nExec;
  time          tEnd;
  initial begin
    for (int i = 0; i < 256; i++) page[i] = 8'hff;
    {write_enable_latch, d1, op, byn, bc, nExec, tEnd} = '0;
  end
  assign prog = op inside {8'h32, 8'h34, 8'hc2, 8'h3e};
  assign erase = op inside {8'h20, 8'h21, 8'h52, 8'h5c, 8'hd8, 8'hdc};
  assign alen = (fourByte || op inside {8'h34, 8'h3e, 8'h21, 8'h5c, 8'hdc}) ? 4 : 3;
  assign quad = byn > 0 && (op inside {8'hc2, 8'h3e} || prog && byn > alen);
  assign drv = !flashCsN && byn > 0 && op == 8'h05;
  // Undriven IO0, IO2 and IO3 show the inverse of their last level; IO1 shows d1 while driving status, else ~d1
  assign ioIn = (ioOe & ioOut) | (~ioOe & {~ioOut[3:2], drv ? d1 : ~d1, ~ioOut[0]});
  always @(negedge flashCsN) begin
    {byn, bc, nDat, hit, addr} = '0;
  end
  always @(posedge flashSclk) begin
    sh = quad ? {sh[3:0], ioIn} : {sh[6:0], ioIn[0]};
    bc = bc + (quad ? 4'h4 : 4'h1);
    if (bc == 4'h8) begin
      bc = 4'h0;
      if (byn == 0) op = sh;
      else if (byn <= alen) addr = {addr[23:0], sh};
      else begin
        lat[8'(addr[7:0] + nDat)] = sh;
        hit[8'(addr[7:0] + nDat)] = 1'b1;
        nDat++;
      end
      byn++;
      if (byn == 1 && op == 8'h05) outSh = {6'h00, write_enable_latch, $time < tEnd};
    end
  end
  always @(negedge flashSclk) if (drv) begin
    d1 = outSh[7];
    outSh = {outSh[6:0], 1'b0};
  end
  always @(posedge flashCsN) begin
    if (bc == 0 && byn == 1 && op == 8'h06 && !wrenDead) write_enable_latch = 1'b1;
    if (bc == 0 && write_enable_latch && (prog ? byn > alen + 1 : erase && byn == alen + 1) && !protect) begin
      write_enable_latch = 1'b0;
      tEnd = $time + BUSY_NS;
      lastOp = op;
      lastAddr = addr;
      nExec++;
      for (int i = 0; i < 256; i++) if (hit[i]) page[i] = lat[i];
    end
  end
endmodule

// file: dv/qspi_prog_host_test.sv
// Self-checking bench for the quad flash program/erase host
`timescale 1ns/10ps
module qspi_prog_host_test;
  import qspi_host_pkg::*;
  localparam int BUSY = 20000;
  typedef struct {
    logic [2:0]  kind;
    logic        a4;
    logic        d4;
    logic [31:0] addr;
    logic [7:0]  len;
    logic [7:0]  op;
  } row_t;
  // Kind, four-byte mode, dedicated opcode, address, count minus one, wire opcode
  row_t rows [11] = '{
    '{3'h0, 1'b0, 1'b0, 32'h00012305, 8'h02, 8'h32},
    '{3'h0, 1'b0, 1'b1, 32'h89abcd40, 8'h00, 8'h34},
    '{3'h1, 1'b1, 1'b0, 32'h12345680, 8'h03, 8'hc2},
    '{3'h1, 1'b0, 1'b1, 32'h7700aac0, 8'h01, 8'h3e},
    '{3'h2, 1'b0, 1'b0, 32'h55fff123, 8'h00, 8'h20},
    '{3'h2, 1'b1, 1'b0, 32'h40001777, 8'h00, 8'h20},
    '{3'h2, 1'b0, 1'b1, 32'hc0000fff, 8'h00, 8'h21},
    '{3'h3, 1'b0, 1'b0, 32'h00ab7ffe, 8'h00, 8'h52},
    '{3'h3, 1'b1, 1'b1, 32'h0a018001, 8'h00, 8'h5c},
    '{3'h4, 1'b0, 1'b0, 32'h00fe0000, 8'h00, 8'hd8},
    '{3'h4, 1'b1, 1'b1, 32'hffffffff, 8'h00, 8'hdc}
  };
  logic        clk = 1'b0, reset = 1'b1;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        fourByte = 1'b0, protect = 1'b0, wrenDead = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, flashCsN, flashSclk;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [3:0]  ioIn, ioOut, ioOe;
  int          mismatches = 0, cmpCount = 0;
  qspi_prog_host dut (.clk, .reset, .ce(1'b1), .awaddr, .awvalid, .awready, .wdata,
    .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .flashCsN, .flashSclk, .ioIn, .ioOut, .ioOe);
  flash_model #(.BUSY_NS(BUSY)) flash (.flashCsN, .flashSclk, .ioOut, .ioOe, .ioIn,
    .fourByte, .protect, .wrenDead);
  initial forever #25 clk = ~clk;
  task automatic final_report;
    if (mismatches == 0 && cmpCount > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmpCount++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Address and data offered together; response taken before anything moves
  task automatic axiWr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge clk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    while (bvalid !== 1'b1) @(posedge clk);
    bready <= 1'b0;
    check("bresp", 32'(er), 32'(bresp));
    @(posedge clk);
  endtask
  task automatic axiRd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge clk);
    d = rdata;
    rs = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask
  // Poll ends on done or on a skipped command
  task automatic runCmd(input logic [31:0] ctrl, output logic [31:0] st);
    logic [1:0] rs;
    axiWr(REG_CTRL, ctrl, RESP_OKAY);
    do axiRd(REG_STATUS, st, rs); while (st[1] !== 1'b1 && st[2] !== 1'b1);
  endtask
  initial begin
    #3000000;
    mismatches++;
    final_report();
  end
  initial begin
    logic [31:0] st, d;
    logic [1:0]  rs;
    logic [7:0]  pre;
    time         t0;
    int          n;
    row_t        r;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    axiRd(REG_STATUS, d, rs);
    check("status reset", 32'h0, d);
    axiRd(REG_CTRL, d, rs);
    check("ctrl reset", 32'h0, d);
    axiRd(REG_BUF, d, rs);
    check("buf read", 32'h0, d);
    axiRd(8'h20, d, rs);
    check("unmapped rresp", 32'(RESP_SLVERR), 32'(rs));
    axiWr(8'h24, 32'h1, RESP_SLVERR);
    foreach (rows[i]) begin
      r = rows[i];
      fourByte <= r.a4;
      if (r.kind < 3'h2)
        for (int j = 0; j <= r.len; j++) axiWr(REG_BUF, {16'h0, 8'(j), 8'(j * 7 + i)}, RESP_OKAY);
      axiWr(REG_ADDR, r.addr, RESP_OKAY);
      axiWr(REG_LEN, {24'h0, r.len}, RESP_OKAY);
      pre = flash.page[8'(r.addr[7:0] + r.len + 1)];
      t0 = $time;
      runCmd({26'h0, r.d4, r.a4, r.kind, 1'b1}, st);
      check("status", 32'h2, st);
      check("busy span", 32'h1, 32'($time - t0 >= BUSY));
      check("opcode", 32'(r.op), 32'(flash.lastOp));
      check("address", r.a4 | r.d4 ? r.addr : {8'h0, r.addr[23:0]}, flash.lastAddr);
      if (r.kind < 3'h2) begin
        for (int j = 0; j <= r.len; j++)
          check("page byte", 32'(8'(j * 7 + i)), 32'(flash.page[8'(r.addr[7:0] + j)]));
        check("page rest", 32'(pre), 32'(flash.page[8'(r.addr[7:0] + r.len + 1)]));
      end
    end
    axiRd(REG_CTRL, d, rs);
    check("ctrl readback", 32'h38, d);
    for (int j = 0; j < 256; j++) axiWr(REG_BUF, {16'h0, 8'(j), 8'(j) ^ 8'ha5}, RESP_OKAY);
    axiWr(REG_ADDR, 32'h000345f0, RESP_OKAY);
    axiWr(REG_LEN, 32'hff, RESP_OKAY);
    fourByte <= 1'b0;
    runCmd(32'h1, st);
    for (int j = 0; j < 256; j++)
      check("wrapped byte", 32'(8'(j) ^ 8'ha5), 32'(flash.page[8'(8'hf0 + j)]));
    n = flash.nExec;
    wrenDead <= 1'b1;
    runCmd({28'h0, 3'h2, 1'b1}, st);
    check("welErr", 32'h1, 32'(st[2]));
    wrenDead <= 1'b0;
    protect <= 1'b1;
    runCmd({28'h0, 3'h4, 1'b1}, st);
    check("notExec", 32'h1, 32'(st[3]));
    check("exec count", 32'(n), 32'(flash.nExec));
    // Reset in mid-frame: pins and status must come back idle
    axiWr(REG_CTRL, 32'h1, RESP_OKAY);
    repeat (40) @(posedge clk);
    reset <= 1'b1;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    check("pins after reset", 32'h20, 32'({flashCsN, flashSclk, ioOe}));
    axiRd(REG_STATUS, d, rs);
    check("status after reset", 32'h0, d);
    final_report();
  end
endmodule
